//--- design/clk_src_pkg.sv
package clk_src_pkg;

    // register offsets of the clock source block
    localparam logic [7:0] OFS_PLL_DSP_SRC = 8'h0d;
    localparam logic [7:0] OFS_DAC_OSR_SRC = 8'h0e;
    localparam logic [7:0] OFS_CP_SRC = 8'h0f;
    localparam logic [7:0] OFS_DSP_DAC_GPIO = 8'h10;
    localparam logic [7:0] OFS_CP_OSR_GPIO = 8'h11;
    localparam logic [7:0] OFS_PLL_REF_GPIO = 8'h12;

    // field positions (low bit of each 3-bit field)
    localparam int HI_FIELD_LSB = 4;
    localparam int LO_FIELD_LSB = 0;
    localparam int SEL_W = 3;

    // reset values
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // gpio pin codes shared by every pin selector
    localparam logic [2:0] PIN_CODE_ZERO = 3'h3;
    localparam logic [2:0] PIN_CODE_TWO = 3'h5;

    // source codes of each divider selector
    localparam logic [2:0] DAC_GPIO_CODE = 3'h5;
    localparam logic [2:0] DSP_GPIO_CODE = 3'h5;
    localparam logic [2:0] CP_GPIO_CODE = 3'h6;
    localparam logic [2:0] OSR_GPIO_CODE = 3'h6;
    localparam logic [2:0] REF_GPIO_CODE = 3'h3;

    // clocks offered to the selectors, sampled as ordinary levels
    typedef struct packed {
        logic auto_master;
        logic pll;
        logic osc;
        logic mclk;
        logic sclk;
        logic general_pin_zero;
        logic general_pin_two;
    } clk_sources_t;

    // selected divider inputs
    typedef struct packed {
        logic dsp;
        logic dac;
        logic osr;
        logic cp;
        logic pll_ref;
    } divider_inputs_t;

    // register read and write strobes with address and write data
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

//--- design/gpio_pin_pick.sv
`timescale 1ns/1ps
module gpio_pin_pick
    import clk_src_pkg::*;
(
    // pin selector
    input wire logic [2:0] pin_sel,
    // candidate pins
    input wire logic pin_zero,
    input wire logic pin_two,
    // picked level
    output logic picked
);
    // n/a and reserved codes both fall into the muted case
    wire is_zero = (pin_sel == PIN_CODE_ZERO);
    wire is_two = (pin_sel == PIN_CODE_TWO);

    assign picked = (is_zero & pin_zero) | (is_two & pin_two);
endmodule

//--- design/code_source_mux.sv
`timescale 1ns/1ps
module code_source_mux
    import clk_src_pkg::*;
#(
    parameter int SEL_WIDTH = 3
) (
    // selector code
    input wire logic [SEL_WIDTH-1:0] sel,
    // one candidate per code; unused codes are tied low by the caller
    input wire logic [(1<<SEL_WIDTH)-1:0] candidates,
    // selected level
    output logic chosen
);
    assign chosen = candidates[sel];
endmodule

//--- design/divider_clock_source_select.sv
`timescale 1ns/1ps
//
// Contract
// - dac divider: six sources, else mute
// - osr divider: dac clock first, then six sources, 111 mutes
// - charge-pump divider: seven sources, 111 mutes
// - dsp gpio pick: 011 pin zero, 101 two
// - dac gpio pick: 011 pin zero, 101 two
// - charge-pump gpio pick: 011 zero, 101 two
// - osr gpio pick: 011 zero, 101 two
// - pll reference gpio pick: 011 zero, 101 two
// - pll reference source, overridden in auto mode
// - dsp divider source, gpio at 101
module divider_clock_source_select
    import clk_src_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // auto-set mode override of the pll reference
    input wire logic auto_set_mode,
    input wire logic [2:0] auto_pll_ref_sel,
    // candidate clocks
    input wire clk_sources_t srcs,
    // selected divider inputs
    output divider_inputs_t div_in
);

    logic [2:0] pll_ref_src_sel_r;
    logic [2:0] dsp_divider_source_sel_r;
    logic [2:0] dac_divider_source_sel_r;
    logic [2:0] oversample_divider_source_sel_r;
    logic [2:0] charge_pump_divider_source_sel_r;
    logic [2:0] dsp_gpio_pin_sel_r;
    logic [2:0] dac_gpio_pin_sel_r;
    logic [2:0] charge_pump_gpio_pin_sel_r;
    logic [2:0] oversample_gpio_pin_sel_r;
    logic [2:0] pll_ref_gpio_pin_sel_r;
    logic [7:0] reg_rdata_r;
    divider_inputs_t div_in_r;
    divider_inputs_t div_in_nxt;

    function automatic logic [7:0] pack_pair(input logic [2:0] hi, input logic [2:0] lo);
        pack_pair = 8'h00;
        pack_pair[HI_FIELD_LSB +: SEL_W] = hi;
        pack_pair[LO_FIELD_LSB +: SEL_W] = lo;
    endfunction

    // register decode
    wire wr_pll_dsp = reg_req.wr && (reg_req.addr == OFS_PLL_DSP_SRC);
    wire wr_dac_osr = reg_req.wr && (reg_req.addr == OFS_DAC_OSR_SRC);
    wire wr_cp = reg_req.wr && (reg_req.addr == OFS_CP_SRC);
    wire wr_dsp_dac_gpio = reg_req.wr && (reg_req.addr == OFS_DSP_DAC_GPIO);
    wire wr_cp_osr_gpio = reg_req.wr && (reg_req.addr == OFS_CP_OSR_GPIO);
    wire wr_ref_gpio = reg_req.wr && (reg_req.addr == OFS_PLL_REF_GPIO);
    wire [2:0] wr_hi = reg_req.wdata[HI_FIELD_LSB +: SEL_W];
    wire [2:0] wr_lo = reg_req.wdata[LO_FIELD_LSB +: SEL_W];

    always_ff @(posedge clk) begin
        if (rst) begin
            pll_ref_src_sel_r <= SEL_RESET;
            dsp_divider_source_sel_r <= SEL_RESET;
        end else if (wr_pll_dsp) begin
            pll_ref_src_sel_r <= wr_hi;
            dsp_divider_source_sel_r <= wr_lo;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dac_divider_source_sel_r <= SEL_RESET;
            oversample_divider_source_sel_r <= SEL_RESET;
        end else if (wr_dac_osr) begin
            dac_divider_source_sel_r <= wr_hi;
            oversample_divider_source_sel_r <= wr_lo;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            charge_pump_divider_source_sel_r <= SEL_RESET;
        end else if (wr_cp) begin
            charge_pump_divider_source_sel_r <= wr_lo;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dsp_gpio_pin_sel_r <= SEL_RESET;
            dac_gpio_pin_sel_r <= SEL_RESET;
        end else if (wr_dsp_dac_gpio) begin
            dsp_gpio_pin_sel_r <= wr_hi;
            dac_gpio_pin_sel_r <= wr_lo;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            charge_pump_gpio_pin_sel_r <= SEL_RESET;
            oversample_gpio_pin_sel_r <= SEL_RESET;
        end else if (wr_cp_osr_gpio) begin
            charge_pump_gpio_pin_sel_r <= wr_hi;
            oversample_gpio_pin_sel_r <= wr_lo;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pll_ref_gpio_pin_sel_r <= SEL_RESET;
        end else if (wr_ref_gpio) begin
            pll_ref_gpio_pin_sel_r <= wr_lo;
        end
    end

    // read-back; reserved bits and unmapped offsets read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_req.addr)
            OFS_PLL_DSP_SRC: rd_mux = pack_pair(pll_ref_src_sel_r, dsp_divider_source_sel_r);
            OFS_DAC_OSR_SRC: rd_mux = pack_pair(dac_divider_source_sel_r,
                                                oversample_divider_source_sel_r);
            OFS_CP_SRC: rd_mux = pack_pair(3'h0, charge_pump_divider_source_sel_r);
            OFS_DSP_DAC_GPIO: rd_mux = pack_pair(dsp_gpio_pin_sel_r, dac_gpio_pin_sel_r);
            OFS_CP_OSR_GPIO: rd_mux = pack_pair(charge_pump_gpio_pin_sel_r,
                                                oversample_gpio_pin_sel_r);
            OFS_PLL_REF_GPIO: rd_mux = pack_pair(3'h0, pll_ref_gpio_pin_sel_r);
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_r <= RDATA_RESET;
        end else if (reg_req.rd) begin
            reg_rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = reg_rdata_r;

    // gpio pin pickers; their result is only used on the gpio code of the divider
    logic dsp_pin;
    logic dac_pin;
    logic cp_pin;
    logic osr_pin;
    logic ref_pin;

    gpio_pin_pick u_dsp_pin (
        .pin_sel(dsp_gpio_pin_sel_r),
        .pin_zero(srcs.general_pin_zero),
        .pin_two(srcs.general_pin_two),
        .picked(dsp_pin)
    );
    gpio_pin_pick u_dac_pin (
        .pin_sel(dac_gpio_pin_sel_r),
        .pin_zero(srcs.general_pin_zero),
        .pin_two(srcs.general_pin_two),
        .picked(dac_pin)
    );
    gpio_pin_pick u_cp_pin (
        .pin_sel(charge_pump_gpio_pin_sel_r),
        .pin_zero(srcs.general_pin_zero),
        .pin_two(srcs.general_pin_two),
        .picked(cp_pin)
    );
    gpio_pin_pick u_osr_pin (
        .pin_sel(oversample_gpio_pin_sel_r),
        .pin_zero(srcs.general_pin_zero),
        .pin_two(srcs.general_pin_two),
        .picked(osr_pin)
    );
    gpio_pin_pick u_ref_pin (
        .pin_sel(pll_ref_gpio_pin_sel_r),
        .pin_zero(srcs.general_pin_zero),
        .pin_two(srcs.general_pin_two),
        .picked(ref_pin)
    );

    // candidate vectors indexed by code, bit 0 = code 000; zeros are muted codes
    wire [7:0] dac_cands = {2'b00, dac_pin, srcs.sclk, srcs.mclk, srcs.osc, srcs.pll,
                            srcs.auto_master};
    wire [7:0] dsp_cands = {2'b00, dsp_pin, srcs.sclk, srcs.mclk, srcs.osc, srcs.pll,
                            srcs.auto_master};
    wire dac_clk;
    wire [7:0] osr_cands = {1'b0, osr_pin, srcs.sclk, srcs.mclk, srcs.osc, srcs.pll,
                            srcs.auto_master, dac_clk};
    wire [7:0] cp_cands = {1'b0, cp_pin, srcs.sclk, srcs.mclk, srcs.osc, srcs.pll,
                           srcs.auto_master, dac_clk};
    wire [7:0] ref_cands = {4'h0, ref_pin, srcs.osc, srcs.sclk, srcs.mclk};

    // auto-set mode takes the pll reference choice away from software
    wire [2:0] ref_sel_eff = auto_set_mode ? auto_pll_ref_sel : pll_ref_src_sel_r;

    wire dsp_clk;
    wire osr_clk;
    wire cp_clk;
    wire ref_clk;

    code_source_mux #(.SEL_WIDTH(SEL_W)) u_dac_mux (
        .sel(dac_divider_source_sel_r),
        .candidates(dac_cands),
        .chosen(dac_clk)
    );
    code_source_mux #(.SEL_WIDTH(SEL_W)) u_dsp_mux (
        .sel(dsp_divider_source_sel_r),
        .candidates(dsp_cands),
        .chosen(dsp_clk)
    );
    code_source_mux #(.SEL_WIDTH(SEL_W)) u_osr_mux (
        .sel(oversample_divider_source_sel_r),
        .candidates(osr_cands),
        .chosen(osr_clk)
    );
    code_source_mux #(.SEL_WIDTH(SEL_W)) u_cp_mux (
        .sel(charge_pump_divider_source_sel_r),
        .candidates(cp_cands),
        .chosen(cp_clk)
    );
    code_source_mux #(.SEL_WIDTH(SEL_W)) u_ref_mux (
        .sel(ref_sel_eff),
        .candidates(ref_cands),
        .chosen(ref_clk)
    );

    // outputs are retimed so the divider sees glitch-free levels, at one cycle of lag
    assign div_in_nxt = '{dsp: dsp_clk, dac: dac_clk, osr: osr_clk, cp: cp_clk,
                          pll_ref: ref_clk};
    always_ff @(posedge clk) begin
        if (rst) begin
            div_in_r <= '0;
        end else begin
            div_in_r <= div_in_nxt;
        end
    end
    assign div_in = div_in_r;

    // checks
    sequence s_dac_on_gpio_zero;
        (dac_divider_source_sel_r == DAC_GPIO_CODE) && (dac_gpio_pin_sel_r == PIN_CODE_ZERO);
    endsequence

    property p_dac_mclk;
        @(posedge clk) disable iff (rst)
        (dac_divider_source_sel_r == 3'h3) |=> (div_in.dac == $past(srcs.mclk));
    endproperty
    a_dac_mclk: assert property (p_dac_mclk) else $error("dac divider not on mclk");

    property p_dac_mute;
        @(posedge clk) disable iff (rst)
        (dac_divider_source_sel_r > 3'h5) |=> !div_in.dac;
    endproperty
    a_dac_mute: assert property (p_dac_mute) else $error("dac divider not muted");

    property p_osr_dac;
        @(posedge clk) disable iff (rst)
        (oversample_divider_source_sel_r == 3'h0) |=> (div_in.osr == div_in.dac);
    endproperty
    a_osr_dac: assert property (p_osr_dac) else $error("osr divider not on dac clock");

    property p_cp_sclk;
        @(posedge clk) disable iff (rst)
        (charge_pump_divider_source_sel_r == 3'h5) |=> (div_in.cp == $past(srcs.sclk));
    endproperty
    a_cp_sclk: assert property (p_cp_sclk) else $error("cp divider not on sclk");

    property p_cp_mute;
        @(posedge clk) disable iff (rst)
        (charge_pump_divider_source_sel_r == 3'h7) |=> !div_in.cp;
    endproperty
    a_cp_mute: assert property (p_cp_mute) else $error("cp divider not muted");

    property p_dsp_pin_two;
        @(posedge clk) disable iff (rst)
        (dsp_divider_source_sel_r == DSP_GPIO_CODE) && (dsp_gpio_pin_sel_r == PIN_CODE_TWO)
        |=> (div_in.dsp == $past(srcs.general_pin_two));
    endproperty
    a_dsp_pin_two: assert property (p_dsp_pin_two) else $error("dsp pin two wrong");

    property p_dac_pin_zero;
        @(posedge clk) disable iff (rst)
        s_dac_on_gpio_zero |=> (div_in.dac == $past(srcs.general_pin_zero));
    endproperty
    a_dac_pin_zero: assert property (p_dac_pin_zero) else $error("dac pin zero wrong");

    property p_cp_pin_reserved;
        @(posedge clk) disable iff (rst)
        (charge_pump_divider_source_sel_r == CP_GPIO_CODE) &&
        (charge_pump_gpio_pin_sel_r == 3'h2) |=> !div_in.cp;
    endproperty
    a_cp_pin_reserved: assert property (p_cp_pin_reserved) else $error("cp pin mute");

    property p_osr_pin_two;
        @(posedge clk) disable iff (rst)
        (oversample_divider_source_sel_r == OSR_GPIO_CODE) &&
        (oversample_gpio_pin_sel_r == PIN_CODE_TWO)
        |=> (div_in.osr == $past(srcs.general_pin_two));
    endproperty
    a_osr_pin_two: assert property (p_osr_pin_two) else $error("osr pin two wrong");

    property p_ref_gpio;
        @(posedge clk) disable iff (rst)
        !auto_set_mode && (pll_ref_src_sel_r == REF_GPIO_CODE) &&
        (pll_ref_gpio_pin_sel_r == PIN_CODE_ZERO)
        |=> (div_in.pll_ref == $past(srcs.general_pin_zero));
    endproperty
    a_ref_gpio: assert property (p_ref_gpio) else $error("pll ref gpio wrong");

    property p_ref_auto;
        @(posedge clk) disable iff (rst)
        auto_set_mode && (auto_pll_ref_sel == 3'h1) |=> (div_in.pll_ref == $past(srcs.sclk));
    endproperty
    a_ref_auto: assert property (p_ref_auto) else $error("auto override ignored");

    property p_pin_ignored;
        @(posedge clk) disable iff (rst)
        (dac_divider_source_sel_r == 3'h4) |=> (div_in.dac == $past(srcs.sclk));
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("pin sel leaked");

    property p_sel_write;
        @(posedge clk) disable iff (rst)
        wr_dac_osr |=> (dac_divider_source_sel_r == $past(reg_req.wdata[6:4]));
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("dac selector write lost");

endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import clk_src_pkg::*;

    typedef struct packed {
        divider_inputs_t div;
        logic chk_rd;
        logic [7:0] rd;
    } exp_t;

    logic clk;
    logic rst;
    reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic auto_set_mode;
    logic [2:0] auto_pll_ref_sel;
    clk_sources_t srcs;
    divider_inputs_t div_in;

    int error_cnt;
    int cmp_count;
    int cyc;
    logic [31:0] seed;
    exp_t expq[$];
    logic [7:0] rm [13:18];
    logic [7:0] addrs [9];
    localparam int CYC_LIMIT = 5000;

    divider_clock_source_select i_dut (
        .clk(clk),
        .rst(rst),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .auto_set_mode(auto_set_mode),
        .auto_pll_ref_sel(auto_pll_ref_sel),
        .srcs(srcs),
        .div_in(div_in)
    );

    always #50 clk = ~clk;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic pin(input logic [2:0] p, input clk_sources_t s);
        return (p == PIN_CODE_ZERO) ? s.general_pin_zero :
               (p == PIN_CODE_TWO) ? s.general_pin_two : 1'b0;
    endfunction

    // shared code map of the dac and dsp selectors; osr/cp reuse it shifted by one
    function automatic logic src6(input logic [2:0] c, input clk_sources_t s, input logic g);
        case (c)
            3'h0: return s.auto_master;
            3'h1: return s.pll;
            3'h2: return s.osc;
            3'h3: return s.mclk;
            3'h4: return s.sclk;
            3'h5: return g;
            default: return 1'b0;
        endcase
    endfunction

    function automatic divider_inputs_t calc(input clk_sources_t s, input logic au,
                                             input logic [2:0] as);
        divider_inputs_t c;
        logic dacv;
        logic [2:0] rc;
        dacv = src6(rm[14][6:4], s, pin(rm[16][2:0], s));
        c.dac = dacv;
        c.dsp = src6(rm[13][2:0], s, pin(rm[16][6:4], s));
        c.osr = (rm[14][2:0] == 3'h0) ? dacv : src6(rm[14][2:0] - 3'h1, s, pin(rm[17][2:0], s));
        c.cp = (rm[15][2:0] == 3'h0) ? dacv : src6(rm[15][2:0] - 3'h1, s, pin(rm[17][6:4], s));
        rc = au ? as : rm[13][6:4];
        c.pll_ref = (rc == 3'h0) ? s.mclk : (rc == 3'h1) ? s.sclk :
                    (rc == 3'h2) ? s.osc : (rc == 3'h3) ? pin(rm[18][2:0], s) : 1'b0;
        return c;
    endfunction

    // called just after a falling edge; the result shows after the next rising edge
    task automatic step(input logic r, input logic w, input logic rdi, input logic [7:0] a,
                        input logic [7:0] d);
        exp_t e;
        logic [31:0] rv;
        logic mapped;
        rv = $random(seed);
        rst = r;
        reg_req.wr = w;
        reg_req.rd = rdi;
        reg_req.addr = a;
        reg_req.wdata = d;
        srcs = clk_sources_t'(rv[6:0]);
        auto_set_mode = (rv[10:8] == 3'h0);
        auto_pll_ref_sel = rv[13:11];
        mapped = (a >= 8'h0d) && (a <= 8'h12);
        if (r) begin
            e.div = '0;
            e.chk_rd = 1'b1;
            e.rd = 8'h00;
            for (int i = 13; i <= 18; i++) begin
                rm[i] = 8'h00;
            end
        end else begin
            e.div = calc(srcs, auto_set_mode, auto_pll_ref_sel);
            e.chk_rd = rdi;
            // a read in the same cycle as a write returns the old contents
            e.rd = (rdi && mapped) ? rm[a] : 8'h00;
            if (w && mapped) begin
                rm[a] = d & (((a == 8'h0f) || (a == 8'h12)) ? 8'h07 : 8'h77);
            end
        end
        expq.push_back(e);
        @(negedge clk);
    endtask

    task automatic rnd_step();
        logic [31:0] op;
        logic [31:0] dv;
        op = $random(seed);
        dv = $random(seed);
        step(1'b0, op[0], op[1], addrs[op[7:4] % 9], dv[7:0]);
    endtask

    always @(posedge clk) begin
        exp_t e;
        #1;
        if (expq.size() > 0) begin
            e = expq.pop_front();
            check("dac", {7'h00, div_in.dac}, {7'h00, e.div.dac});
            check("dsp", {7'h00, div_in.dsp}, {7'h00, e.div.dsp});
            check("osr", {7'h00, div_in.osr}, {7'h00, e.div.osr});
            check("cp", {7'h00, div_in.cp}, {7'h00, e.div.cp});
            check("pll_ref", {7'h00, div_in.pll_ref}, {7'h00, e.div.pll_ref});
            if (e.chk_rd) begin
                check("rdata", reg_rdata, e.rd);
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc >= CYC_LIMIT) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_req = '0;
        auto_set_mode = 1'b0;
        auto_pll_ref_sel = 3'h0;
        srcs = '0;
        error_cnt = 0;
        cmp_count = 0;
        cyc = 0;
        seed = 32'h3f264d49;
        addrs = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h00, 8'h13, 8'hff};
        @(negedge clk);
        step(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        // every code in every field, with reserved bits written as ones first
        for (int a = 13; a <= 18; a++) begin
            step(1'b0, 1'b1, 1'b0, 8'(a), 8'hff);
            step(1'b0, 1'b0, 1'b1, 8'(a), 8'h00);
        end
        for (int c = 0; c < 8; c++) begin
            for (int a = 13; a <= 18; a++) begin
                step(1'b0, 1'b1, 1'b1, 8'(a), {1'b0, 3'(c), 1'b0, 3'(c)});
            end
            repeat (8) rnd_step();
        end
        repeat (1500) rnd_step();
        // reset in mid-run must return every selector to its first code
        step(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        step(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        for (int a = 13; a <= 18; a++) begin
            step(1'b0, 1'b0, 1'b1, 8'(a), 8'h00);
        end
        repeat (1500) rnd_step();
        step(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
        @(posedge clk);
        #2;
        results();
    end
endmodule
